// ==== mipp_pkg.sv ====
// package: constants and types for the maskable irq priority promoter
package mipp_pkg;

  // ==========================================================
  // register map
  localparam int         ADDR_W        = 8;
  localparam int         DATA_W        = 8;
  localparam logic [7:0] PRIO_REG_ADDR = 8'h3C;

  // ==========================================================
  // field layout of irq_promote_and_mode
  localparam int PSEL_LSB  = 0;
  localparam int PSEL_W    = 5;
  localparam int MODE_LSB  = 5;
  localparam int MODE_W    = 3;

  // ==========================================================
  // reset values
  localparam logic [4:0] PSEL_RESET = 5'h06;
  localparam logic [2:0] MODE_CLEAR = 3'h0;

  // ==========================================================
  // sources, default order: index 0 is the highest
  localparam int         NUM_SRC   = 15;
  localparam int         SRC_W     = 4;
  localparam logic [3:0] SRC_EXT   = 4'h0;
  localparam logic [4:0] PSEL_FIRST = 5'h06;
  localparam logic [4:0] PSEL_LAST  = 5'h14;

  // mode bits as stored in the register, msb first
  typedef struct packed {
    logic boot_rom_read;
    logic special_mode_select;
    logic mode_select_a;
  } mipp_mode_t;

  // arbitration result towards the cpu
  typedef struct packed {
    logic             req;
    logic [SRC_W-1:0] src;
  } mipp_grant_t;

endpackage : mipp_pkg

// ==== mipp_top.sv ====
// module: promote register, mode bits and maskable irq arbitration
module mipp_top (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic [mipp_pkg::ADDR_W-1:0]    addr,
  input  wire logic [mipp_pkg::DATA_W-1:0]    wr_data,
  input  wire logic                           wr_en,
  input  wire logic                           rd_en,
  output logic      [mipp_pkg::DATA_W-1:0]    rd_data,
  input  wire logic                           global_irq_mask,
  input  wire mipp_pkg::mipp_mode_t           mode_strap,
  input  wire logic [mipp_pkg::NUM_SRC-1:0]   src_pending,
  output mipp_pkg::mipp_mode_t                mode_bits,
  output logic      [mipp_pkg::PSEL_W-1:0]    promote_select,
  output mipp_pkg::mipp_grant_t               grant
);
  import mipp_pkg::*;

  // ==========================================================
  // state
  logic        [PSEL_W-1:0] psel_r,     psel_nxt;
  mipp_mode_t               mode_r,     mode_nxt;
  logic                     strap_pend_r, strap_pend_nxt;
  logic        [DATA_W-1:0] rd_data_r,  rd_data_nxt;
  mipp_grant_t              grant_r,    grant_nxt;
  logic                     hit;
  logic        [SRC_W-1:0]  prom_idx;
  logic        [SRC_W-1:0]  low_idx;
  logic                     any_pend;

  assign hit = (addr == PRIO_REG_ADDR);

  // ==========================================================
  // promote code decode
  always_comb begin
    if (psel_r >= PSEL_FIRST && psel_r <= PSEL_LAST) begin
      prom_idx = SRC_W'(psel_r - PSEL_FIRST);
    end else begin
      prom_idx = SRC_EXT;
    end
  end

  // ==========================================================
  // default order: lowest pending index
  always_comb begin
    low_idx  = SRC_EXT;
    any_pend = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (src_pending[i]) begin
        low_idx  = SRC_W'(i);
        any_pend = 1'b1;
      end
    end
  end

  // ==========================================================
  // register write and strap capture, next values
  always_comb begin
    psel_nxt       = psel_r;
    mode_nxt       = mode_r;
    strap_pend_nxt = 1'b0;
    if (strap_pend_r) begin
      mode_nxt = mode_strap;
    end else if (wr_en && hit && mode_r.special_mode_select) begin
      mode_nxt = mipp_mode_t'(wr_data[MODE_LSB +: MODE_W]);
    end
    if (wr_en && hit && global_irq_mask) begin
      psel_nxt = wr_data[PSEL_LSB +: PSEL_W];
    end
  end

  // register write state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      psel_r       <= PSEL_RESET;
      mode_r       <= MODE_CLEAR;
      strap_pend_r <= 1'b1;
    end else begin
      psel_r       <= psel_nxt;
      mode_r       <= mode_nxt;
      strap_pend_r <= strap_pend_nxt;
    end
  end

  // ==========================================================
  // read path, data one cycle after the strobe
  always_comb begin
    rd_data_nxt = '0;
    if (rd_en && hit) begin
      rd_data_nxt = {mode_r, psel_r};
    end
  end

  // read data register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // ==========================================================
  // arbitration, next values
  always_comb begin
    grant_nxt.req = any_pend && !global_irq_mask;
    if (src_pending[prom_idx]) begin
      grant_nxt.src = prom_idx;
    end else begin
      grant_nxt.src = low_idx;
    end
  end

  // grant register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      grant_r <= '0;
    end else begin
      grant_r <= grant_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign rd_data        = rd_data_r;
  assign mode_bits      = mode_r;
  assign promote_select = psel_r;
  assign grant          = grant_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_psel_locked;
    wr_en && hit && !global_irq_mask |=> $stable(psel_r);
  endproperty
  a_psel_locked: assert property (p_psel_locked)
    else $error("promote field changed while mask clear");

  property p_psel_write;
    wr_en && hit && global_irq_mask |=>
      psel_r == $past(wr_data[PSEL_LSB +: PSEL_W]);
  endproperty
  a_psel_write: assert property (p_psel_write)
    else $error("promote field write lost");

  property p_promote;
    !global_irq_mask && src_pending[prom_idx] |=>
      grant_r.req && grant_r.src == $past(prom_idx);
  endproperty
  a_promote: assert property (p_promote)
    else $error("promoted source did not win");

  property p_default_order;
    !global_irq_mask && any_pend && !src_pending[prom_idx] |=>
      grant_r.req && grant_r.src == $past(low_idx) &&
      ($past(src_pending) & ~(15'h7FFF << grant_r.src)) == 15'h0000;
  endproperty
  a_default_order: assert property (p_default_order)
    else $error("default order broken");

  property p_decode;
    psel_r >= PSEL_FIRST && psel_r <= PSEL_LAST |->
      PSEL_W'(prom_idx) + PSEL_FIRST == psel_r;
  endproperty
  a_decode: assert property (p_decode)
    else $error("promote code decoded wrongly");

  property p_reserved;
    psel_r < PSEL_FIRST || psel_r > PSEL_LAST |-> prom_idx == SRC_EXT;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved code not mapped to external pin");

  property p_strap;
    strap_pend_r |=> mode_r == $past(mode_strap) && !strap_pend_r;
  endproperty
  a_strap: assert property (p_strap)
    else $error("mode bits not taken from straps");

  property p_mode_locked;
    wr_en && hit && !mode_r.special_mode_select && !strap_pend_r
      |=> $stable(mode_r);
  endproperty
  a_mode_locked: assert property (p_mode_locked)
    else $error("mode bits changed in normal mode");

  property p_masked;
    global_irq_mask |=> !grant_r.req;
  endproperty
  a_masked: assert property (p_masked)
    else $error("request passed while masked");

  property p_read;
    rd_en && hit |=> rd_data_r == {$past(mode_r), $past(psel_r)};
  endproperty
  a_read: assert property (p_read)
    else $error("read data wrong");

  // read data falls back to zero outside the answer cycle
  property p_read_idle;
    !(rd_en && hit) |=> rd_data_r == '0;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data not cleared");

  // ==========================================================
  // hold, mode write, decode and arbitration checks
  // the field only moves on a register write
  property p_psel_hold;
    !(wr_en && hit) |=> $stable(psel_r);
  endproperty
  a_psel_hold: assert property (p_psel_hold)
    else $error("promote field changed without a write");

  // special mode lets a write land in the mode bits
  property p_mode_write;
    wr_en && hit && mode_r.special_mode_select && !strap_pend_r |=>
      mode_r == $past(wr_data[MODE_LSB +: MODE_W]);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode write lost in special mode");

  // without a write, once the straps are loaded, the mode bits keep their value
  property p_mode_hold;
    !(wr_en && hit) && !strap_pend_r |=> $stable(mode_r);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode bits changed without a write");

  // straps load once per reset, later cycles never reload them
  property p_strap_once;
    !strap_pend_r |=> !strap_pend_r;
  endproperty
  a_strap_once: assert property (p_strap_once)
    else $error("strap load repeated");

  // rti and input captures map to their own index
  property p_decode_capt;
    (psel_r == 5'h07 |-> prom_idx == 4'h1) and
    (psel_r == 5'h0A |-> prom_idx == 4'h4);
  endproperty
  a_decode_capt: assert property (p_decode_capt)
    else $error("capture code decoded wrongly");

  // output compares and the shared channel
  property p_decode_cmp;
    (psel_r == 5'h0B |-> prom_idx == 4'h5) and
    (psel_r == 5'h0F |-> prom_idx == 4'h9);
  endproperty
  a_decode_cmp: assert property (p_decode_cmp)
    else $error("compare code decoded wrongly");

  // overflow, accumulator, spi and sci codes
  property p_decode_misc;
    (psel_r == 5'h10 |-> prom_idx == 4'hA) and
    (psel_r == 5'h14 |-> prom_idx == 4'hE);
  endproperty
  a_decode_misc: assert property (p_decode_misc)
    else $error("serial or overflow code decoded wrongly");

  // the granted source was really pending
  property p_grant_pending;
    !global_irq_mask && any_pend |=>
      (($past(src_pending) >> grant_r.src) & 15'h0001) != 15'h0000;
  endproperty
  a_grant_pending: assert property (p_grant_pending)
    else $error("granted source was not pending");

  // nothing pending: no request, source index parked at zero
  property p_idle_src;
    !any_pend |=> !grant_r.req && grant_r.src == SRC_EXT;
  endproperty
  a_idle_src: assert property (p_idle_src)
    else $error("grant raised with nothing pending");

  // an unmasked pending source always raises the request
  property p_unmasked;
    !global_irq_mask && any_pend |=> grant_r.req;
  endproperty
  a_unmasked: assert property (p_unmasked)
    else $error("unmasked request dropped");

  // a read alone changes neither the field nor the mode bits
  property p_read_pure;
    rd_en && hit && !wr_en && !strap_pend_r |=>
      $stable(psel_r) && $stable(mode_r);
  endproperty
  a_read_pure: assert property (p_read_pure)
    else $error("read disturbed the register");

  // ==========================================================
  // cover points
  c_promote_win: cover property (!global_irq_mask &&
    src_pending[prom_idx] && low_idx != prom_idx ##1 grant_r.req);
  c_psel_write: cover property (wr_en && hit && global_irq_mask);
  c_mode_write: cover property (wr_en && hit &&
    mode_r.special_mode_select && !strap_pend_r);
  c_reserved: cover property (psel_r == 5'h1F);
  c_default_win: cover property (!global_irq_mask && any_pend &&
    !src_pending[prom_idx] ##1 grant_r.req);

endmodule : mipp_top

// ==== mipp_cpu_model.sv ====
// cpu side model: interrupt mask bit and recognition of requests
module mipp_cpu_model (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  mask_req,
  input  wire mipp_pkg::mipp_grant_t grant,
  output logic                       global_irq_mask,
  output logic                       taken
);
  timeunit 1ns;
  timeprecision 1ps;
  import mipp_pkg::*;
  // =====================================================
  // mask bit: software sets it before touching the field
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      global_irq_mask <= 1'b1;
    end else begin
      global_irq_mask <= mask_req;
    end
  end
  // recognise a request only while unmasked
  assign taken = grant.req & ~global_irq_mask;
endmodule : mipp_cpu_model

// ==== maskable_irq_priority_promoter_tb.sv ====
// testbench: register access, promotion decode and mode protection
module maskable_irq_priority_promoter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mipp_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wr_data = 8'h00;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [7:0]  rd_data;
  logic        mask_req = 1'b1;
  logic        global_irq_mask;
  logic        taken;
  logic [14:0] src_pending = 15'h7FFF;
  logic [4:0]  promote_select;
  mipp_mode_t  mode_strap = 3'b010;
  mipp_mode_t  mode_bits;
  mipp_grant_t grant;
  int          mismatches = 0;
  int          cmp_count = 0;
  mipp_top mipp_top_inst (.clk(clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .global_irq_mask(global_irq_mask), .mode_strap(mode_strap),
    .src_pending(src_pending), .mode_bits(mode_bits),
    .promote_select(promote_select), .grant(grant));
  mipp_cpu_model mipp_cpu_model_inst (.clk(clk), .rst(rst),
    .mask_req(mask_req), .grant(grant),
    .global_irq_mask(global_irq_mask), .taken(taken));
  // =====================================================
  // clock and bus tasks
  always #5 clk = ~clk;
  task stop_test;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk8(rd_data, exp);
    if (a == PRIO_REG_ADDR) begin
      chk8({mode_bits, promote_select}, exp);
    end
  endtask : rd
  task msk(input logic v);
    @(posedge clk);
    mask_req <= v;
    repeat (2) @(posedge clk);
  endtask : msk
  // promote a code with the mask set, then unmask and check
  task promo(input logic [4:0] c, input logic [7:0] exp);
    msk(1'b1);
    #1 chk8({6'h0, taken, grant.req}, 8'h00);
    wr(PRIO_REG_ADDR, {3'b010, c});
    msk(1'b0);
    repeat (2) @(posedge clk);
    #1 chk8({2'h0, taken, grant}, exp);
  endtask : promo
  // =====================================================
  // test sequence
  initial begin
    logic [3:0] e;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(PRIO_REG_ADDR, 8'h46);
    for (int c = 0; c < 32; c++) begin
      e = (c >= 6 && c <= 20) ? 4'(c - 6) : 4'h0;
      promo(5'(c), {4'h3, e});
    end
    @(posedge clk);
    src_pending <= 15'h0208;
    promo(5'h0B, 8'h33);
    promo(5'h0F, 8'h39);
    @(posedge clk);
    src_pending <= 15'h0000;
    repeat (2) @(posedge clk);
    #1 chk8({2'h0, taken, grant}, 8'h00);
    wr(PRIO_REG_ADDR, 8'h4C);
    rd(PRIO_REG_ADDR, 8'h4F);
    msk(1'b1);
    wr(PRIO_REG_ADDR, 8'hA6);
    rd(PRIO_REG_ADDR, 8'hA6);
    wr(PRIO_REG_ADDR, 8'hE6);
    rd(PRIO_REG_ADDR, 8'hA6);
    wr(8'h3D, 8'hFF);
    rd(8'h3D, 8'h00);
    rd(PRIO_REG_ADDR, 8'hA6);
    wr(PRIO_REG_ADDR, 8'h13);
    rd(PRIO_REG_ADDR, 8'hB3);
    // second reset with other straps
    @(posedge clk);
    mode_strap <= 3'b001;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(PRIO_REG_ADDR, 8'h26);
    stop_test();
  end
  // watchdog against a hang
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule : maskable_irq_priority_promoter_tb
